// *** rtl/tune_device.sv ***
`timescale 1ns/1ps
module tune_device #(
	parameter logic [3:0] factory_range  = 4'h9,
	parameter bit         soft_oe_fitted = 1'b1
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// register port
	tune_if.device           link,
	// divider and output control
	output logic [25:0]      div_word,
	output logic [15:0]      div_span_q4,
	output logic [9:0]       div_step_e13,
	output logic             div_load,
	output logic             freq_settled,
	output logic             out_enable,
	output logic             out_running
);
	logic [15:0] lower_half;
	logic [15:0] upper_half;
	logic [3:0]  range_code;
	logic [15:0] dly_cnt;
	logic [15:0] settle_cnt;
	logic [15:0] oe_cnt;

	// register writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lower_half <= tune_pkg::lower_reset;
			upper_half <= tune_pkg::upper_reset;
			range_code <= factory_range;
		end
		else if (ce && link.wr_en)
		begin
			case (link.addr)
				tune_pkg::reg_lower: lower_half <= link.wdata;
				tune_pkg::reg_upper: upper_half <= link.wdata;
				tune_pkg::reg_range: range_code <= link.wdata[3:0];
				default: ;
			endcase
		end
	end

	// register reads, answered one cycle later
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			link.rdata  <= 16'h0000;
			link.rvalid <= 1'b0;
		end
		else if (ce)
		begin
			link.rvalid <= link.rd_en;
			case (link.addr)
				tune_pkg::reg_lower: link.rdata <= lower_half;
				tune_pkg::reg_upper: link.rdata <= upper_half;
				tune_pkg::reg_range: link.rdata <= {12'h000, range_code};
				default: link.rdata <= 16'h0000;
			endcase
		end
	end

	// divider reload after the delay, triggered only by the upper half
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dly_cnt      <= 16'h0000;
			div_load     <= 1'b0;
			div_word     <= 26'h000_0000;
			div_span_q4  <= tune_pkg::span_q4(factory_range);
			div_step_e13 <= tune_pkg::step_e13(factory_range);
		end
		else if (ce)
		begin
			div_load <= 1'b0;
			if (link.wr_en && link.addr == tune_pkg::reg_upper)
				dly_cnt <= 16'(tune_pkg::delay_cycles);
			else if (dly_cnt != 16'h0000)
			begin
				dly_cnt <= dly_cnt - 16'h0001;
				if (dly_cnt == 16'h0001)
				begin
					div_load     <= 1'b1;
					div_word     <= tune_pkg::clamp_word({upper_half[9:0], lower_half});
					div_span_q4  <= tune_pkg::span_q4(range_code);
					div_step_e13 <= tune_pkg::step_e13(range_code);
				end
			end
		end
	end

	// settling indication; the output is never gated here
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			settle_cnt   <= 16'h0000;
			freq_settled <= 1'b1;
			out_running  <= 1'b1;
		end
		else if (ce)
		begin
			out_running <= 1'b1;
			if (div_load)
			begin
				settle_cnt   <= 16'(tune_pkg::settle_cycles);
				freq_settled <= 1'b0;
			end
			else if (settle_cnt != 16'h0000)
			begin
				settle_cnt <= settle_cnt - 16'h0001;
				if (settle_cnt == 16'h0001)
					freq_settled <= 1'b1;
			end
		end
	end

	// output enable follows bit 10 after the enable interval
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			oe_cnt     <= 16'h0000;
			out_enable <= !soft_oe_fitted;
		end
		else if (ce)
		begin
			if (link.wr_en && link.addr == tune_pkg::reg_upper)
				oe_cnt <= 16'(tune_pkg::enable_cycles);
			else if (oe_cnt != 16'h0000)
			begin
				oe_cnt <= oe_cnt - 16'h0001;
				if (oe_cnt == 16'h0001)
					out_enable <= upper_half[tune_pkg::oe_bit] || !soft_oe_fitted;
			end
		end
	end
endmodule

// *** rtl/tune_host.sv ***
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module tune_host (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// axi4-lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// device side
	tune_if.host             link
);
	typedef enum logic [7:0] {
		st_idle     = 8'b0000_0001,
		st_rd       = 8'b0000_0010,
		st_rd_wait  = 8'b0000_0100,
		st_wr_lo    = 8'b0000_1000,
		st_wr_up    = 8'b0001_0000,
		st_wr_range = 8'b0010_0000,
		st_wr_oe    = 8'b0100_0000,
		st_gap      = 8'b1000_0000
	} state_t;

	state_t      state;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic        aw_held;
	logic        w_held;
	logic [31:0] arg;
	logic [4:0]  cmd;
	logic [15:0] shadow;
	logic        reenable;
	logic        oe_val;
	logic [15:0] gap_cnt;
	logic        wr_fire;
	logic        cmd_take;
	logic [25:0] word;

	assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
	assign cmd_take = wr_fire && aw_addr == tune_pkg::cmd_addr && state == st_idle;

	// saturate the software integer into the 26-bit signed word
	always_comb
	begin
		if ($signed(arg) > $signed({6'h00, tune_pkg::word_max}))
			word = tune_pkg::word_max;
		else if ($signed(arg) < -$signed({6'h00, tune_pkg::word_max}))
			word = tune_pkg::word_min;
		else
			word = arg[25:0];
	end

	// axi write channels, address and data taken in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= tune_pkg::resp_okay;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			arg           <= 32'h0000_0000;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr       <= s_axi_awaddr;
				aw_held       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data       <= s_axi_wdata;
				w_held       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= tune_pkg::resp_okay;
				if (aw_addr == tune_pkg::arg_addr)
					arg <= w_data;
				else if (aw_addr != tune_pkg::cmd_addr || state != st_idle)
					s_axi_bresp <= tune_pkg::resp_slverr;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// axi read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= tune_pkg::resp_okay;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= tune_pkg::resp_okay;
				case (s_axi_araddr)
					tune_pkg::cmd_addr:    s_axi_rdata <= {27'h000_0000, cmd};
					tune_pkg::arg_addr:    s_axi_rdata <= arg;
					tune_pkg::status_addr: s_axi_rdata <= {31'h0000_0000, state != st_idle};
					tune_pkg::shadow_addr: s_axi_rdata <= {16'h0000, shadow};
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= tune_pkg::resp_slverr;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// sequencer driving the device register port
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state      <= st_idle;
			cmd        <= 5'h00;
			shadow     <= 16'h0000;
			reenable   <= 1'b0;
			oe_val     <= 1'b0;
			gap_cnt    <= 16'h0000;
			link.wr_en <= 1'b0;
			link.rd_en <= 1'b0;
			link.addr  <= tune_pkg::reg_lower;
			link.wdata <= 16'h0000;
		end
		else if (ce)
		begin
			link.wr_en <= 1'b0;
			link.rd_en <= 1'b0;
			case (state)
				st_idle:
					if (cmd_take)
					begin
						cmd    <= w_data[4:0];
						oe_val <= arg[0];
						if (w_data[1:0] == tune_pkg::op_range)
							state <= st_wr_range;
						else if (w_data[1:0] != 2'h0)
							state <= st_rd;
					end
				st_rd:
				begin
					link.rd_en <= 1'b1;
					link.addr  <= tune_pkg::reg_upper;
					state      <= st_rd_wait;
				end
				st_rd_wait:
					if (link.rvalid)
					begin
						shadow   <= link.rdata;
						reenable <= cmd[tune_pkg::wrap_bit] && link.rdata[tune_pkg::oe_bit];
						oe_val   <= (cmd[1:0] == tune_pkg::op_oe) ? oe_val : link.rdata[tune_pkg::oe_bit];
						state    <= (cmd[1:0] == tune_pkg::op_oe) ? st_wr_oe : st_wr_lo;
					end
				st_wr_lo:
				begin
					link.wr_en <= 1'b1;
					link.addr  <= tune_pkg::reg_lower;
					link.wdata <= word[15:0];
					state      <= st_wr_up;
				end
				st_wr_up:
				begin
					link.wr_en <= 1'b1;
					link.addr  <= tune_pkg::reg_upper;
					link.wdata <= {shadow[15:11], oe_val && !reenable, word[25:16]};
					shadow     <= {shadow[15:11], oe_val && !reenable, word[25:16]};
					gap_cnt    <= 16'(tune_pkg::gap_cycles);
					state      <= st_gap;
				end
				st_wr_range:
				begin
					link.wr_en <= 1'b1;
					link.addr  <= tune_pkg::reg_range;
					link.wdata <= {12'h000, arg[3:0]};
					gap_cnt    <= 16'(tune_pkg::gap_cycles);
					state      <= st_gap;
				end
				st_wr_oe:
				begin
					link.wr_en <= 1'b1;
					link.addr  <= tune_pkg::reg_upper;
					link.wdata <= {shadow[15:11], oe_val || reenable, shadow[9:0]};
					shadow     <= {shadow[15:11], oe_val || reenable, shadow[9:0]};
					reenable   <= 1'b0;
					gap_cnt    <= 16'(tune_pkg::gap_cycles);
					state      <= st_gap;
				end
				st_gap:
				begin
					gap_cnt <= gap_cnt - 16'h0001;
					if (gap_cnt == 16'h0001)
						state <= reenable ? st_wr_oe : st_idle;
				end
				default: state <= st_idle;
			endcase
		end
	end
endmodule

// *** rtl/tune_if.sv ***
`timescale 1ns/1ps
interface tune_if;
	logic        wr_en;
	logic        rd_en;
	logic [1:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        rvalid;

	modport device (input wr_en, input rd_en, input addr, input wdata, output rdata, output rvalid);
	modport host   (output wr_en, output rd_en, output addr, output wdata, input rdata, input rvalid);
endinterface

// *** rtl/tune_pkg.sv ***
package tune_pkg;
	// device register map
	localparam logic [1:0]  reg_lower       = 2'h0;
	localparam logic [1:0]  reg_upper       = 2'h1;
	localparam logic [1:0]  reg_range       = 2'h2;
	localparam int          word_w          = 26;
	localparam int          upper_word_w    = 10;
	localparam int          oe_bit          = 10;
	localparam int          range_w         = 4;
	localparam logic [15:0] lower_reset     = 16'h0000;
	localparam logic [15:0] upper_reset     = 16'h0000;
	localparam logic [25:0] word_max        = 26'h1ff_ffff;
	localparam logic [25:0] word_min        = 26'h200_0001;

	// timing
	localparam int clk_hz          = 40_000_000;
	localparam int clk_ns          = 25;
	localparam int update_rate_hz  = 38_000;
	localparam int delay_ns        = 1000;
	localparam int settle_ns       = 10000;
	localparam int enable_ns       = 1000;
	localparam int gap_cycles      = (clk_hz + update_rate_hz - 1) / update_rate_hz;
	localparam int delay_cycles    = (delay_ns + clk_ns - 1) / clk_ns;
	localparam int settle_cycles   = (settle_ns + clk_ns - 1) / clk_ns;
	localparam int enable_cycles   = (enable_ns + clk_ns - 1) / clk_ns;

	// controller register map
	localparam logic [7:0]  cmd_addr        = 8'h00;
	localparam logic [7:0]  arg_addr        = 8'h04;
	localparam logic [7:0]  status_addr     = 8'h08;
	localparam logic [7:0]  shadow_addr     = 8'h0c;
	localparam logic [1:0]  op_word         = 2'h1;
	localparam logic [1:0]  op_range        = 2'h2;
	localparam logic [1:0]  op_oe           = 2'h3;
	localparam int          wrap_bit        = 4;
	localparam logic [1:0]  resp_okay       = 2'h0;
	localparam logic [1:0]  resp_slverr     = 2'h2;

	// half-width of the span in quarter ppm
	function automatic logic [15:0] span_q4(input logic [3:0] code);
		logic [15:0] s;
		s = 16'h0000;
		case (code)
			4'h0: s = 16'd25;
			4'h1: s = 16'd40;
			4'h2: s = 16'd50;
			4'h3: s = 16'd100;
			4'h4: s = 16'd200;
			4'h5: s = 16'd320;
			4'h6: s = 16'd400;
			4'h7: s = 16'd500;
			4'h8: s = 16'd600;
			4'h9: s = 16'd800;
			4'ha: s = 16'd1600;
			4'hb: s = 16'd2400;
			4'hc: s = 16'd3200;
			4'hd: s = 16'd4800;
			4'he: s = 16'd6400;
			default: s = 16'd12800;
		endcase
		return s;
	endfunction

	// frequency step in units of 1e-13
	function automatic logic [9:0] step_e13(input logic [3:0] code);
		logic [9:0] r;
		r = 10'd50;
		case (code)
			4'ha: r = 10'd100;
			4'hb: r = 10'd140;
			4'hc: r = 10'd210;
			4'hd: r = 10'd320;
			4'he: r = 10'd470;
			4'hf: r = 10'd940;
			default: r = 10'd50;
		endcase
		return r;
	endfunction

	// full scale is +/-(2^25-1); the lone most negative code is pulled in
	function automatic logic [25:0] clamp_word(input logic [25:0] w);
		return (w == 26'h200_0000) ? word_min : w;
	endfunction
endpackage

// *** sim/digital_pull_control_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module digital_pull_control_tb;
	logic        aclk = 1'b0;
	logic        ce = 1'b1;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [25:0] div_word;
	logic [15:0] span;
	logic [9:0]  step;
	logic        div_load, settled, oe, running, st_q, oe_q;
	int          fails = 0, check_count = 0, cyc = 0, oe_chg = 0;
	int          up_cyc, ld_cyc, fall_cyc, rise_cyc, oe_cyc;
	localparam logic [15:0] spans [16] = '{16'h0019, 16'h0028, 16'h0032, 16'h0064, 16'h00c8, 16'h0140,
		16'h0190, 16'h01f4, 16'h0258, 16'h0320, 16'h0640, 16'h0960, 16'h0c80, 16'h12c0, 16'h1900, 16'h3200};
	localparam logic [9:0]  steps [6] = '{10'h064, 10'h08c, 10'h0d2, 10'h140, 10'h1d6, 10'h3ac};

	tune_if tune_if_inst ();
	tune_host tune_host_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .link(tune_if_inst.host));
	tune_device tune_device_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce), .link(tune_if_inst.device),
		.div_word(div_word), .div_span_q4(span), .div_step_e13(step), .div_load(div_load),
		.freq_settled(settled), .out_enable(oe), .out_running(running));
	tune_link_sva tune_link_sva_inst (.aclk(aclk), .aresetn(aresetn), .wr_en(tune_if_inst.wr_en),
		.rd_en(tune_if_inst.rd_en), .addr(tune_if_inst.addr), .wdata(tune_if_inst.wdata),
		.rdata(tune_if_inst.rdata), .rvalid(tune_if_inst.rvalid));

	always #12.5 aclk = ~aclk;

	// edge-sampled event times on the device side
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		st_q <= settled;
		oe_q <= oe;
		if (tune_if_inst.wr_en && tune_if_inst.addr == tune_pkg::reg_upper) up_cyc <= cyc;
		if (div_load) ld_cyc <= cyc;
		if (st_q && !settled) fall_cyc <= cyc;
		if (!st_q && settled) rise_cyc <= cyc;
		if (aresetn && oe_q !== oe) oe_chg <= oe_chg + 1;
		if (aresetn && oe_q !== oe) oe_cyc <= cyc;
		if (aresetn && running !== 1'b1) fails <= fails + 1;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		`CHK("bresp", er, bresp)
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		`CHK("rresp", er, rresp)
	endtask

	// polls busy; running out of polls counts as a mismatch
	task automatic wait_idle;
		logic [31:0] s;
		s = 32'h0000_0001;
		for (int i = 0; i < 2000 && s[0] !== 1'b0; i++) rd(tune_pkg::status_addr, s, tune_pkg::resp_okay);
		`CHK("busy", 1'b0, s[0])
	endtask

	task automatic cmd(input logic [31:0] arg, input logic [4:0] c);
		wr(tune_pkg::arg_addr, arg, tune_pkg::resp_okay);
		wr(tune_pkg::cmd_addr, {27'h0, c}, tune_pkg::resp_okay);
		wait_idle();
	endtask

	task automatic t_reset;
		`CHK("div_word", 26'h000_0000, div_word)
		`CHK("span", 16'h0320, span)
		`CHK("oe", 1'b0, oe)
		`CHK("settled", 1'b1, settled)
	endtask

	task automatic t_pull;
		logic [31:0] d;
		cmd(32'h00e6_6666, {3'h0, tune_pkg::op_word});
		`CHK("div_word", 26'h0e6_6666, div_word)
		`CHK("delay", tune_pkg::delay_cycles + 1, ld_cyc - up_cyc)
		`CHK("settle", tune_pkg::settle_cycles, rise_cyc - fall_cyc)
		rd(tune_pkg::shadow_addr, d, tune_pkg::resp_okay);
		`CHK("upper", 32'h0000_00e6, d)
	endtask

	task automatic t_ranges;
		for (int c = 0; c < 16; c++)
		begin
			cmd(c, {3'h0, tune_pkg::op_range});
			cmd(32'hff80_0000, {3'h0, tune_pkg::op_word});
			`CHK("span", spans[c], span)
			`CHK("step", (c < 10) ? 10'h032 : steps[c - 10], step)
			`CHK("div_word", 26'h380_0000, div_word)
		end
	endtask

	task automatic t_clamp;
		cmd(32'h7fff_ffff, {3'h0, tune_pkg::op_word});
		`CHK("div_word", 26'h1ff_ffff, div_word)
		cmd(32'h8000_0000, {3'h0, tune_pkg::op_word});
		`CHK("div_word", 26'h200_0001, div_word)
	endtask

	task automatic t_oe;
		logic [31:0] d;
		int n;
		cmd(32'h0000_0001, {3'h0, tune_pkg::op_oe});
		`CHK("oe", 1'b1, oe)
		`CHK("oe time", tune_pkg::enable_cycles + 1, oe_cyc - up_cyc)
		rd(tune_pkg::shadow_addr, d, tune_pkg::resp_okay);
		`CHK("oe bit", 1'b1, d[10])
		n = oe_chg;
		cmd(32'h0000_0100, {3'h4, tune_pkg::op_word});
		`CHK("oe toggles", n + 2, oe_chg)
		`CHK("div_word", 26'h000_0100, div_word)
	endtask

	// clock enable low must freeze the enable countdown
	task automatic t_freeze;
		wr(tune_pkg::arg_addr, 32'h0000_0000, tune_pkg::resp_okay);
		wr(tune_pkg::cmd_addr, {30'h0, tune_pkg::op_oe}, tune_pkg::resp_okay);
		do
			@(posedge aclk);
		while (tune_if_inst.wr_en !== 1'b1);
		ce <= 1'b0;
		repeat (100) @(posedge aclk);
		`CHK("frozen oe", 1'b1, oe)
		ce <= 1'b1;
		wait_idle();
		`CHK("oe", 1'b0, oe)
		`CHK("oe time", tune_pkg::enable_cycles + 101, oe_cyc - up_cyc)
	endtask

	task automatic t_refuse;
		logic [31:0] d;
		wr(tune_pkg::status_addr, 32'h0000_0001, tune_pkg::resp_slverr);
		wr(8'h40, 32'h0000_0000, tune_pkg::resp_slverr);
		rd(8'h40, d, tune_pkg::resp_slverr);
		`CHK("unmapped", 32'h0000_0000, d)
		wr(tune_pkg::cmd_addr, {30'h0, tune_pkg::op_word}, tune_pkg::resp_okay);
		wr(tune_pkg::cmd_addr, {30'h0, tune_pkg::op_word}, tune_pkg::resp_slverr);
		wait_idle();
		cmd(32'h0000_0000, {3'h0, tune_pkg::op_word});
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		repeat (90000) @(posedge aclk);
		fails++;
		print_verdict();
	end

	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_pull();
		t_ranges();
		t_clamp();
		t_oe();
		t_freeze();
		t_refuse();
		print_verdict();
	end
endmodule

// *** sim/tune_link_sva.sv ***
`timescale 1ns/1ps
module tune_link_sva (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// link
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [1:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] rdata,
	input  wire logic        rvalid
);
	logic [11:0] gap_cnt;
	logic [15:0] last_upper;
	logic        up_wr;

	assign up_wr = wr_en && addr == tune_pkg::reg_upper;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// cycles since the last upper-half write, saturating
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			gap_cnt <= 12'hfff;
		else if (up_wr)
			gap_cnt <= 12'h000;
		else if (gap_cnt != 12'hfff)
			gap_cnt <= gap_cnt + 12'h001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			last_upper <= tune_pkg::upper_reset;
		else if (up_wr)
			last_upper <= wdata;
	end

	rd_answer_a: assert property (rd_en |=> rvalid)
		else $error("read strobe not answered");
	rvalid_cause_a: assert property (rvalid |-> $past(rd_en))
		else $error("read answer without strobe");
	upper_readback_a: assert property (rvalid && $past(addr) == tune_pkg::reg_upper |-> rdata == last_upper)
		else $error("upper half reads back wrong");
	read_first_a: assert property (wr_en && addr == tune_pkg::reg_lower |->
		$past(rvalid, 2) && $past(rd_en, 3) && $past(addr, 3) == tune_pkg::reg_upper)
		else $error("lower write not preceded by upper read");
	lower_upper_a: assert property (wr_en && addr == tune_pkg::reg_lower |=> up_wr)
		else $error("upper write does not follow lower write");
	keep_bits_a: assert property (up_wr |-> wdata[15:11] == last_upper[15:11])
		else $error("upper control bits altered");
	rate_gap_a: assert property (up_wr |-> int'(gap_cnt) + 1 >= tune_pkg::gap_cycles)
		else $error("tuning updates too close");
	strobes_excl_a: assert property (!(wr_en && rd_en))
		else $error("read and write strobes together");
endmodule
